// ---- logic/fccs_top.sv ----
// Contact-closure capture, pass/fail, filters, result memory and statistics
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

module fccs_top #(
	parameter int DEB_CYCLES = fccs_pkg::DEB_CYC,
	parameter int DISP_FAST_CYCLES = fccs_pkg::DISP_FAST_CYC,
	parameter int DISP_SLOW_CYCLES = fccs_pkg::DISP_SLOW_CYC,
	parameter int PEAK_1K_CYCLES = fccs_pkg::PEAK_1K_CYC,
	parameter int PEAK_100_CYCLES = fccs_pkg::PEAK_100_CYC,
	parameter int PEAK_10_CYCLES = fccs_pkg::PEAK_10_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire fccs_pkg::fccs_axi_req_t axi_req,
	output fccs_pkg::fccs_axi_rsp_t axi_rsp,
	input wire logic signed [fccs_pkg::LOAD_W-1:0] load_sample,
	input wire logic load_valid,
	input wire logic contact_sense,
	output logic irq,
	output logic open_event_freeze_indicator,
	output logic close_event_freeze_indicator,
	output logic pass_indication,
	output logic fail_indication
);
	import fccs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	fccs_ctrl_t ctrl_q;
	logic signed [LOAD_W-1:0] lim_a_q, lim_b_q, last_load_q, cap_q, disp_q, tens_q, comp_q;
	logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
	logic sense_s1_q, sense_s2_q, sense_stable_q, sense_init_q, rise_q, fall_q;
	logic [CNT_W-1:0] deb_cnt_q, disp_cnt_q, disp_n_q, pk_cnt_q, pk_n_q, pk_lim;
	logic signed [SUM_W-1:0] disp_sum_q, pk_sum_q;
	logic frozen_q, pass_q, fail_q, cc_active, sw_event, in_lim, disp_tick, pk_tick;
	logic signed [LOAD_W:0] lim_lo, lim_hi, ld_ext;
	logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q, wr_go, rd_go, rd_ok;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q, rd_data;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic cmd_wr, do_save, do_clr1, do_clrall, save_refused;
	logic [IDX_W-1:0] cmd_idx, count_q, st_idx_q, pidx_q;
	logic signed [LOAD_W-1:0] mem_q [MEM_DEPTH];
	fccs_state_t st_q;
	fccs_view_t view_q;
	logic signed [23:0] acc_sum_q;
	logic [SUM_W-1:0] acc_sq_q;
	logic signed [LOAD_W-1:0] max_q, min_q, mean_q;
	logic [31:0] var_q, cov_q, pct_q;
	logic [LOAD_W-1:0] sdev_q, root_try;
	logic [3:0] bit_q;
	logic [31:0] root_sq;
	logic [47:0] var_num, var_den, cov_num;
	logic [23:0] sum_abs;
	logic [LOAD_W-1:0] mean_abs;
	logic signed [47:0] pa, pb, pct_num;
	logic stats_done_q;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel
	assign axi_rsp.awready = !aw_hold_q && !bvalid_q;
	assign axi_rsp.wready = !w_hold_q && !bvalid_q;
	assign axi_rsp.bvalid = bvalid_q;
	assign axi_rsp.bresp = bresp_q;
	assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			if (axi_req.awvalid && axi_rsp.awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= axi_req.awaddr;
			end
			if (axi_req.wvalid && axi_rsp.wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= axi_req.wdata;
				wstrb_q <= axi_req.wstrb;
			end
			if (wr_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= (awaddr_q[1:0] == 2'h0 && awaddr_q <= A_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && axi_req.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Writable registers
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ctrl_q <= CTRL_RESET;
			lim_a_q <= '0;
			lim_b_q <= '0;
			irq_mask_q <= '0;
		end else if (wr_go) begin
			case (awaddr_q)
				A_CTRL: ctrl_q <= fccs_ctrl_t'(wmerge(32'(ctrl_q), wdata_q, wstrb_q));
				A_LIM_A: lim_a_q <= LOAD_W'(wmerge(32'(lim_a_q), wdata_q, wstrb_q));
				A_LIM_B: lim_b_q <= LOAD_W'(wmerge(32'(lim_b_q), wdata_q, wstrb_q));
				A_IRQ_MASK: irq_mask_q <= IRQ_W'(wmerge(32'(irq_mask_q), wdata_q, wstrb_q));
				default: ;
			endcase
		end
	end

	assign cmd_wr = wr_go && awaddr_q == A_CMD && wstrb_q[0];
	assign cmd_idx = wdata_q[CMD_IDX_LSB +: IDX_W];

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	assign axi_rsp.arready = !rvalid_q;
	assign axi_rsp.rvalid = rvalid_q;
	assign axi_rsp.rdata = rdata_q;
	assign axi_rsp.rresp = rresp_q;
	assign rd_go = axi_req.arvalid && !rvalid_q;

	always_comb begin
		rd_ok = 1'b1;
		case (axi_req.araddr)
			A_CTRL: rd_data = 32'(ctrl_q);
			A_LIM_A: rd_data = 32'(lim_a_q);
			A_LIM_B: rd_data = 32'(lim_b_q);
			A_CAPTURE: rd_data = 32'({fail_q, pass_q, frozen_q, cap_q});
			A_DISPLAY: rd_data = 32'(disp_q);
			A_PEAK: rd_data = {comp_q, tens_q};
			A_CMD: rd_data = '0;
			A_MEMINFO: rd_data = 32'({view_q, st_q != ST_IDLE, count_q == IDX_W'(MEM_DEPTH), count_q});
			A_MEAN: rd_data = 32'(mean_q);
			A_MAXMIN: rd_data = {min_q, max_q};
			A_SDEV: rd_data = 32'(sdev_q);
			A_VAR: rd_data = var_q;
			A_COV: rd_data = cov_q;
			A_PCTDIFF: rd_data = pct_q;
			A_IRQ_STAT: rd_data = 32'(irq_stat_q);
			A_IRQ_MASK: rd_data = 32'(irq_mask_q);
			default: begin
				rd_data = '0;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (rd_go) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_data;
			rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && axi_req.rready) begin
			rvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky, read to clear, new events win
	assign irq_ev[IRQ_CAPTURE] = sw_event && cc_active && !frozen_q;
	assign irq_ev[IRQ_MEMFULL] = save_refused;
	assign irq_ev[IRQ_STATS] = stats_done_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= ((rd_go && axi_req.araddr == A_IRQ_STAT) ? '0 : irq_stat_q) | irq_ev;
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	////////////////////////////////////////////////////////////////////////////
	// Contact sense synchroniser, debounce and edge detect
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sense_s1_q <= 1'b0;
			sense_s2_q <= 1'b0;
		end else begin
			sense_s1_q <= contact_sense;
			sense_s2_q <= sense_s1_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sense_stable_q <= 1'b0;
			sense_init_q <= 1'b0;
			deb_cnt_q <= '0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			rise_q <= 1'b0;
			fall_q <= 1'b0;
			if (sense_init_q && sense_s2_q == sense_stable_q) begin
				deb_cnt_q <= '0;
			end else if (deb_cnt_q >= CNT_W'(DEB_CYCLES - 1)) begin
				deb_cnt_q <= '0;
				sense_stable_q <= sense_s2_q;
				sense_init_q <= 1'b1;
				rise_q <= sense_init_q && sense_s2_q && !sense_stable_q;
				fall_q <= sense_init_q && !sense_s2_q && sense_stable_q;
			end else begin
				deb_cnt_q <= deb_cnt_q + 1'b1;
			end
		end
	end

	assign cc_active = ctrl_q.cc_enable && ctrl_q.cc_mode;
	assign sw_event = ctrl_q.cc_close ? rise_q : fall_q;

	////////////////////////////////////////////////////////////////////////////
	// Capture and pass/fail
	always_comb begin
		ld_ext = (LOAD_W + 1)'(last_load_q);
		if (ctrl_q.pf_nominal) begin
			lim_lo = (LOAD_W + 1)'(lim_a_q) - (LOAD_W + 1)'(lim_b_q);
			lim_hi = (LOAD_W + 1)'(lim_a_q) + (LOAD_W + 1)'(lim_b_q);
		end else begin
			lim_lo = (LOAD_W + 1)'(lim_a_q);
			lim_hi = (LOAD_W + 1)'(lim_b_q);
		end
		in_lim = ld_ext >= lim_lo && ld_ext <= lim_hi;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			last_load_q <= '0;
		end else if (load_valid) begin
			last_load_q <= load_sample;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			frozen_q <= 1'b0;
			cap_q <= '0;
			pass_q <= 1'b0;
			fail_q <= 1'b0;
		end else if (!cc_active || (cmd_wr && wdata_q[CMD_REARM])) begin
			frozen_q <= 1'b0;
			pass_q <= 1'b0;
			fail_q <= 1'b0;
		end else if (sw_event && !frozen_q) begin
			frozen_q <= 1'b1;
			cap_q <= last_load_q;
			pass_q <= ctrl_q.pf_enable && in_lim;
			fail_q <= ctrl_q.pf_enable && !in_lim;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			open_event_freeze_indicator <= 1'b0;
			close_event_freeze_indicator <= 1'b0;
			pass_indication <= 1'b0;
			fail_indication <= 1'b0;
		end else begin
			open_event_freeze_indicator <= cc_active && !ctrl_q.cc_close;
			close_event_freeze_indicator <= cc_active && ctrl_q.cc_close;
			pass_indication <= pass_q;
			fail_indication <= fail_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Display filter on the instantaneous value
	assign disp_tick = disp_cnt_q >= (ctrl_q.disp_slow ? CNT_W'(DISP_SLOW_CYCLES - 1) : CNT_W'(DISP_FAST_CYCLES - 1));

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			disp_cnt_q <= '0;
			disp_n_q <= '0;
			disp_sum_q <= '0;
			disp_q <= '0;
		end else if (disp_tick) begin
			disp_cnt_q <= '0;
			disp_n_q <= '0;
			disp_sum_q <= '0;
			if (disp_n_q != '0) begin
				disp_q <= LOAD_W'(disp_sum_q / $signed(SUM_W'(disp_n_q)));
			end
		end else begin
			disp_cnt_q <= disp_cnt_q + 1'b1;
			if (load_valid) begin
				disp_n_q <= disp_n_q + 1'b1;
				disp_sum_q <= disp_sum_q + SUM_W'(load_sample);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Peak filter, independent of the display filter
	always_comb begin
		case (ctrl_q.peak_rate)
			2'h0: pk_lim = CNT_W'(PEAK_10K_CYC - 1);
			2'h1: pk_lim = CNT_W'(PEAK_1K_CYCLES - 1);
			2'h2: pk_lim = CNT_W'(PEAK_100_CYCLES - 1);
			default: pk_lim = CNT_W'(PEAK_10_CYCLES - 1);
		endcase
	end

	assign pk_tick = pk_cnt_q >= pk_lim;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pk_cnt_q <= '0;
			pk_n_q <= '0;
			pk_sum_q <= '0;
			tens_q <= LOAD_MIN;
			comp_q <= LOAD_MAX;
		end else if (cmd_wr && wdata_q[CMD_PKCLR]) begin
			pk_cnt_q <= '0;
			pk_n_q <= '0;
			pk_sum_q <= '0;
			tens_q <= LOAD_MIN;
			comp_q <= LOAD_MAX;
		end else if (pk_tick) begin
			pk_cnt_q <= '0;
			pk_n_q <= '0;
			pk_sum_q <= '0;
			if (pk_n_q != '0) begin
				if (LOAD_W'(pk_sum_q / $signed(SUM_W'(pk_n_q))) > tens_q) begin
					tens_q <= LOAD_W'(pk_sum_q / $signed(SUM_W'(pk_n_q)));
				end
				if (LOAD_W'(pk_sum_q / $signed(SUM_W'(pk_n_q))) < comp_q) begin
					comp_q <= LOAD_W'(pk_sum_q / $signed(SUM_W'(pk_n_q)));
				end
			end
		end else begin
			pk_cnt_q <= pk_cnt_q + 1'b1;
			if (load_valid) begin
				pk_n_q <= pk_n_q + 1'b1;
				pk_sum_q <= pk_sum_q + SUM_W'(load_sample);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result memory
	assign do_save = cmd_wr && wdata_q[CMD_SAVE] && frozen_q && st_q == ST_IDLE && count_q < IDX_W'(MEM_DEPTH);
	assign save_refused = cmd_wr && wdata_q[CMD_SAVE] && count_q == IDX_W'(MEM_DEPTH);
	assign do_clr1 = cmd_wr && wdata_q[CMD_CLR1] && st_q == ST_IDLE && cmd_idx < count_q;
	assign do_clrall = cmd_wr && wdata_q[CMD_CLRALL] && st_q == ST_IDLE;

	for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_mem
		localparam int NXT = (i < MEM_DEPTH - 1) ? i + 1 : i;
		always_ff @(posedge clk_sys) begin
			if (!rst_b) begin
				mem_q[i] <= '0;
			end else if (do_save && count_q == IDX_W'(i)) begin
				mem_q[i] <= cap_q;
			end else if (do_clr1 && IDX_W'(i) >= cmd_idx) begin
				mem_q[i] <= (i < MEM_DEPTH - 1) ? mem_q[NXT] : '0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			count_q <= '0;
		end else if (do_clrall) begin
			count_q <= '0;
		end else if (do_clr1) begin
			count_q <= count_q - 1'b1;
		end else if (do_save) begin
			count_q <= count_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Statistics view cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			view_q <= VIEW_MEAN;
		end else if (cmd_wr && wdata_q[CMD_VIEW]) begin
			case (view_q)
				VIEW_MEAN: view_q <= VIEW_COV;
				VIEW_COV: view_q <= VIEW_PCT;
				VIEW_PCT: view_q <= VIEW_SDEV;
				VIEW_SDEV: view_q <= VIEW_MEAN;
				default: view_q <= VIEW_MEAN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Statistics engine
	assign sum_abs = acc_sum_q < 0 ? 24'(-acc_sum_q) : 24'(acc_sum_q);
	assign mean_abs = mean_q < 0 ? LOAD_W'(-mean_q) : LOAD_W'(mean_q);
	assign var_num = 48'(count_q) * 48'(acc_sq_q) - 48'(sum_abs) * 48'(sum_abs);
	assign var_den = 48'(count_q) * 48'(count_q - 1'b1);
	assign root_try = sdev_q | (LOAD_W'(1) << bit_q);
	assign root_sq = 32'(root_try) * 32'(root_try);
	assign cov_num = 48'(sdev_q) * 48'(PCT_SCALE);
	assign pa = 48'(mem_q[pidx_q]);
	assign pb = (pidx_q < IDX_W'(MEM_DEPTH - 1)) ? 48'(mem_q[pidx_q + 1'b1]) : 48'(0);
	assign pct_num = (pb - pa) * 48'(PCT_SCALE);

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st_q <= ST_IDLE;
			st_idx_q <= '0;
			pidx_q <= '0;
			acc_sum_q <= '0;
			acc_sq_q <= '0;
			max_q <= '0;
			min_q <= '0;
			mean_q <= '0;
			var_q <= '0;
			sdev_q <= '0;
			bit_q <= '0;
			cov_q <= '0;
			pct_q <= '0;
			stats_done_q <= 1'b0;
		end else begin
			stats_done_q <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					if (cmd_wr && wdata_q[CMD_STATS]) begin
						st_q <= ST_ACC;
						st_idx_q <= '0;
						pidx_q <= cmd_idx;
						acc_sum_q <= '0;
						acc_sq_q <= '0;
						max_q <= LOAD_MIN;
						min_q <= LOAD_MAX;
					end
				end
				ST_ACC: begin
					if (st_idx_q >= count_q) begin
						st_q <= ST_MEAN;
					end else begin
						acc_sum_q <= acc_sum_q + 24'(mem_q[st_idx_q]);
						acc_sq_q <= acc_sq_q + SUM_W'($unsigned(32'(mem_q[st_idx_q] * mem_q[st_idx_q])));
						if (mem_q[st_idx_q] > max_q) begin
							max_q <= mem_q[st_idx_q];
						end
						if (mem_q[st_idx_q] < min_q) begin
							min_q <= mem_q[st_idx_q];
						end
						st_idx_q <= st_idx_q + 1'b1;
					end
				end
				ST_MEAN: begin
					mean_q <= (count_q != '0) ? LOAD_W'(acc_sum_q / $signed(24'(count_q))) : '0;
					st_q <= ST_VAR;
				end
				ST_VAR: begin
					var_q <= (count_q > IDX_W'(1)) ? 32'(var_num / var_den) : '0;
					sdev_q <= '0;
					bit_q <= 4'(LOAD_W - 1);
					st_q <= ST_ROOT;
				end
				ST_ROOT: begin
					if (root_sq <= var_q) begin
						sdev_q <= root_try;
					end
					if (bit_q == '0) begin
						st_q <= ST_DERIV;
					end else begin
						bit_q <= bit_q - 1'b1;
					end
				end
				ST_DERIV: begin
					cov_q <= (mean_abs != '0) ? 32'(cov_num / 48'(mean_abs)) : '0;
					pct_q <= (pidx_q + 1'b1 < count_q && pa != 0) ? 32'(pct_num / pa) : '0;
					stats_done_q <= 1'b1;
					st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

endmodule

// ---- logic/fccs_pkg.sv ----
// Constants, register map and types for the force capture and statistics block
package fccs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int CLK_HZ = 20000000;
	localparam int US_PER_S = 1000000;
	localparam int DEB_TIME_US = 2000;
	localparam int DEB_CYC = DEB_TIME_US * (CLK_HZ / US_PER_S);
	localparam int DISP_FAST_HZ = 10;
	localparam int DISP_SLOW_HZ = 4;
	localparam int DISP_FAST_CYC = CLK_HZ / DISP_FAST_HZ;
	localparam int DISP_SLOW_CYC = CLK_HZ / DISP_SLOW_HZ;
	localparam int PEAK_10K_HZ = 10000;
	localparam int PEAK_1K_HZ = 1000;
	localparam int PEAK_100_HZ = 100;
	localparam int PEAK_10_HZ = 10;
	localparam int PEAK_10K_CYC = CLK_HZ / PEAK_10K_HZ;
	localparam int PEAK_1K_CYC = CLK_HZ / PEAK_1K_HZ;
	localparam int PEAK_100_CYC = CLK_HZ / PEAK_100_HZ;
	localparam int PEAK_10_CYC = CLK_HZ / PEAK_10_HZ;
	localparam int CNT_W = 24;

	////////////////////////////////////////////////////////////////////////////
	// Data widths and sizes
	localparam int LOAD_W = 16;
	localparam int SUM_W = 40;
	localparam int MEM_DEPTH = 100;
	localparam int IDX_W = 7;
	localparam int PCT_SCALE = 10000;
	localparam logic signed [LOAD_W-1:0] LOAD_MIN = 16'h8000;
	localparam logic signed [LOAD_W-1:0] LOAD_MAX = 16'h7FFF;

	////////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] A_LIM_A = 8'h04;
	localparam logic [ADDR_W-1:0] A_LIM_B = 8'h08;
	localparam logic [ADDR_W-1:0] A_CAPTURE = 8'h0C;
	localparam logic [ADDR_W-1:0] A_DISPLAY = 8'h10;
	localparam logic [ADDR_W-1:0] A_PEAK = 8'h14;
	localparam logic [ADDR_W-1:0] A_CMD = 8'h18;
	localparam logic [ADDR_W-1:0] A_MEMINFO = 8'h1C;
	localparam logic [ADDR_W-1:0] A_MEAN = 8'h20;
	localparam logic [ADDR_W-1:0] A_MAXMIN = 8'h24;
	localparam logic [ADDR_W-1:0] A_SDEV = 8'h28;
	localparam logic [ADDR_W-1:0] A_VAR = 8'h2C;
	localparam logic [ADDR_W-1:0] A_COV = 8'h30;
	localparam logic [ADDR_W-1:0] A_PCTDIFF = 8'h34;
	localparam logic [ADDR_W-1:0] A_IRQ_STAT = 8'h38;
	localparam logic [ADDR_W-1:0] A_IRQ_MASK = 8'h3C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Command register bits
	localparam int CMD_SAVE = 0;
	localparam int CMD_CLR1 = 1;
	localparam int CMD_CLRALL = 2;
	localparam int CMD_STATS = 3;
	localparam int CMD_VIEW = 4;
	localparam int CMD_REARM = 5;
	localparam int CMD_PKCLR = 6;
	localparam int CMD_IDX_LSB = 8;

	// Interrupt status bits
	localparam int IRQ_CAPTURE = 0;
	localparam int IRQ_MEMFULL = 1;
	localparam int IRQ_STATS = 2;
	localparam int IRQ_W = 3;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {VIEW_MEAN, VIEW_COV, VIEW_PCT, VIEW_SDEV} fccs_view_t;
	typedef enum logic [2:0] {ST_IDLE, ST_ACC, ST_MEAN, ST_VAR, ST_ROOT, ST_DERIV} fccs_state_t;

	typedef struct packed {
		logic cc_mode;
		logic [1:0] peak_rate;
		logic disp_slow;
		logic pf_nominal;
		logic pf_enable;
		logic cc_close;
		logic cc_enable;
	} fccs_ctrl_t;

	localparam fccs_ctrl_t CTRL_RESET = 8'h00;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic [2:0] awprot;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic [2:0] arprot;
		logic rready;
	} fccs_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} fccs_axi_rsp_t;

endpackage

// ---- dv/fccs_sva.sv ----
// Port checker for the force capture and statistics block
`timescale 1ns/1ns
module fccs_sva #(
	parameter int DEB_CYCLES = 4
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire fccs_pkg::fccs_axi_req_t axi_req,
	input wire fccs_pkg::fccs_axi_rsp_t axi_rsp,
	input wire logic contact_sense,
	input wire logic open_event_freeze_indicator,
	input wire logic close_event_freeze_indicator,
	input wire logic pass_indication,
	input wire logic fail_indication
);
	import fccs_pkg::*;
	logic [15:0] stab_q;
	logic sense_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////////
	// Cycles the sense pin has held its level
	always_ff @(posedge clk_sys) begin
		sense_q <= contact_sense;
		if (!rst_b || contact_sense != sense_q) begin
			stab_q <= 16'h0;
		end else if (stab_q != 16'hFFFF) begin
			stab_q <= stab_q + 16'h1;
		end
	end
	sequence wr_both;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence
	sequence rd_taken;
		axi_req.arvalid && axi_rsp.arready;
	endsequence
	sequence verdict_up;
		$rose(pass_indication || fail_indication);
	endsequence
	////////////////////////////////////////////////////////////////////////////
	ind_excl_a: assert property (!(open_event_freeze_indicator && close_event_freeze_indicator))
		else $error("both freeze indicators high");
	verdict_excl_a: assert property (!(pass_indication && fail_indication))
		else $error("pass and fail both high");
	verdict_settled_a: assert property (verdict_up |-> stab_q >= DEB_CYCLES)
		else $error("capture on unsettled sense input");
	edge_polarity_a: assert property (verdict_up ##0 (open_event_freeze_indicator || close_event_freeze_indicator)
		|-> contact_sense == close_event_freeze_indicator) else $error("capture on wrong edge");
	write_answer_a: assert property (wr_both |-> ##2 axi_rsp.bvalid) else $error("no write response");
	bvalid_drop_a: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid) else $error("bvalid stuck");
	read_answer_a: assert property (rd_taken |=> axi_rsp.rvalid) else $error("no read data");
	rvalid_drop_a: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid) else $error("rvalid stuck");
	ar_block_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready) else $error("read taken while busy");
endmodule
bind fccs_top fccs_sva #(.DEB_CYCLES(DEB_CYCLES)) fccs_sva_inst (.clk_sys, .rst_b, .axi_req, .axi_rsp,
	.contact_sense, .open_event_freeze_indicator, .close_event_freeze_indicator, .pass_indication,
	.fail_indication);

// ---- dv/fccs_switch_model.sv ----
// Switch under test with contact bounce
`timescale 1ns/1ns
module fccs_switch_model (
	input wire logic clk_sys,
	input wire logic level_req,
	output logic contact_sense
);
	logic last_q = 1'b1;
	logic [2:0] bnc_q = 3'h0;
	// One-cycle glitches after each change of level
	always_ff @(posedge clk_sys) begin
		if (level_req != last_q) begin
			last_q <= level_req;
			bnc_q <= 3'h5;
		end else if (bnc_q != 3'h0) begin
			bnc_q <= bnc_q - 3'h1;
		end
	end
	assign contact_sense = (bnc_q != 3'h0 && !bnc_q[0]) ? !last_q : last_q;
endmodule

// ---- dv/test_force_capture_contact_stats.sv ----
// Testbench for the force capture and statistics block
`timescale 1ns/1ns
module test_force_capture_contact_stats;
	import fccs_pkg::*;
	logic clk_sys = 0;
	logic rst_b = 0;
	fccs_axi_req_t axi_req = '0;
	fccs_axi_rsp_t axi_rsp;
	logic signed [LOAD_W-1:0] load_sample = '0;
	logic load_valid = 1;
	logic sw_level = 1;
	logic contact_sense, irq, pass_indication, fail_indication;
	logic open_event_freeze_indicator, close_event_freeze_indicator;
	int n_errors = 0;
	int cmp_count = 0;
	logic [31:0] d;
	logic [1:0] r;
	always #25 clk_sys = ~clk_sys;
	fccs_top #(.DEB_CYCLES(4), .DISP_FAST_CYCLES(40), .PEAK_1K_CYCLES(20))
		fccs_top_inst (.clk_sys, .rst_b, .axi_req, .axi_rsp, .load_sample, .load_valid,
		.contact_sense, .irq, .open_event_freeze_indicator, .close_event_freeze_indicator, .pass_indication,
		.fail_indication);
	fccs_switch_model fccs_switch_model_inst (.clk_sys, .level_req(sw_level), .contact_sense);
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int t;
		t = 0;
		axi_req.awvalid <= 1;
		axi_req.awaddr <= a;
		axi_req.wvalid <= 1;
		axi_req.wdata <= v;
		do begin
			@(posedge clk_sys);
			if (axi_rsp.awready) axi_req.awvalid <= 0;
			if (axi_rsp.wready) axi_req.wvalid <= 0;
			t++;
		end while (axi_rsp.bvalid !== 1'b1 && t < 99);
		chk("bvalid", 32'h1, 32'(axi_rsp.bvalid));
		r = axi_rsp.bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		axi_req.arvalid <= 1;
		axi_req.araddr <= a;
		do @(posedge clk_sys); while (axi_rsp.arready !== 1'b1);
		axi_req.arvalid <= 0;
		do @(posedge clk_sys); while (axi_rsp.rvalid !== 1'b1);
		d = axi_rsp.rdata;
		r = axi_rsp.rresp;
	endtask
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, d);
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 80 && irq !== 1'b1; i++) @(posedge clk_sys);
	endtask
	task automatic cap(input logic [15:0] ld, input logic lv, input logic [31:0] st);
		load_sample <= ld;
		sw_level <= lv;
		wait_irq();
		rc("cap", A_CAPTURE, st);
		rc("ist", A_IRQ_STAT, 32'h1);
		chk("pf", 32'(st[18:17]), {30'h0, fail_indication, pass_indication});
	endtask
	task automatic arm(input logic [31:0] c, input logic lv);
		wr(A_CMD, 32'h20);
		wr(A_CTRL, c);
		sw_level <= lv;
		wait_irq();
	endtask
	task automatic end_of_test();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rc("ctrl", A_CTRL, 32'h0);
		rd(8'h40);
		chk("resp", 32'(RESP_SLVERR), 32'(r));
		wr(8'h41, 32'h0);
		chk("bresp", 32'(RESP_SLVERR), 32'(r));
		for (int i = 1; i < 5; i++) begin
			wr(A_CMD, 32'h10);
			rd(A_MEMINFO);
			chk("view", i % 4, 32'(d[10:9]));
		end
	endtask
	task automatic t_open();
		wr(A_IRQ_MASK, 32'h7);
		chk("bresp", 32'(RESP_OKAY), 32'(r));
		wr(A_LIM_A, 32'h64);
		wr(A_LIM_B, 32'hC8);
		wr(A_CTRL, 32'h85);
		cap(16'h64, 0, 32'h0003_0064);
		chk("ind", 32'h1, {30'h0, close_event_freeze_indicator, open_event_freeze_indicator});
		load_sample <= 16'h12C;
		sw_level <= 1;
		wait_irq();
		rc("cap", A_CAPTURE, 32'h0003_0064);
		wr(A_CMD, 32'h1);
	endtask
	task automatic t_close();
		wr(A_LIM_B, 32'h64);
		arm(32'h8F, 0);
		cap(16'hC8, 1, 32'h0003_00C8);
		chk("ind", 32'h2, {30'h0, close_event_freeze_indicator, open_event_freeze_indicator});
		wr(A_CMD, 32'h1);
		arm(32'h8F, 0);
		cap(16'h12C, 1, 32'h0005_012C);
		wr(A_CMD, 32'h1);
	endtask
	task automatic t_stats();
		logic [31:0] pct [2] = '{32'h2710, 32'h1388};
		for (int k = 0; k < 2; k++) begin
			wr(A_CMD, 32'h8 | (k << 8));
			wait_irq();
			rc("ist", A_IRQ_STAT, 32'h4);
			rc("pct", A_PCTDIFF, pct[k]);
		end
		rc("mean", A_MEAN, 32'hC8);
		rc("mm", A_MAXMIN, 32'h0064_012C);
		rc("var", A_VAR, 32'h2710);
		rc("sdev", A_SDEV, 32'h64);
		rc("cov", A_COV, 32'h1388);
	endtask
	task automatic t_full();
		repeat (97) wr(A_CMD, 32'h1);
		rd(A_MEMINFO);
		chk("full", 32'hE4, 32'(d[8:0]));
		wr(A_IRQ_MASK, 32'h5);
		wr(A_CMD, 32'h1);
		chk("irq", 32'h0, 32'(irq));
		rc("ist", A_IRQ_STAT, 32'h2);
		wr(A_CMD, 32'h2);
		rd(A_MEMINFO);
		chk("cnt", 32'h63, 32'(d[8:0]));
		wr(A_CMD, 32'h4);
		rd(A_MEMINFO);
		chk("cnt", 32'h0, 32'(d[8:0]));
	endtask
	task automatic t_off();
		wr(A_CTRL, 32'h0);
		rd(A_CAPTURE);
		chk("frz", 32'h0, 32'(d[16]));
		chk("ind", 32'h0, {30'h0, close_event_freeze_indicator, open_event_freeze_indicator});
		sw_level <= 0;
		wait_irq();
		rc("ist", A_IRQ_STAT, 32'h0);
	endtask
	task automatic t_filt();
		for (int k = 0; k < 2; k++) begin
			wr(A_CTRL, 32'(k << 5));
			wr(A_CMD, 32'h40);
			repeat (30) @(posedge clk_sys);
			rc("peak", A_PEAK, k ? 32'h012C_012C : 32'h7FFF_8000);
		end
		rc("disp", A_DISPLAY, 32'h012C);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#500000;
		n_errors++;
		end_of_test();
	end
	initial begin
		axi_req.bready <= 1;
		axi_req.rready <= 1;
		axi_req.wstrb <= 4'hF;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1;
		repeat (20) @(posedge clk_sys);
		t_reset();
		t_open();
		t_close();
		t_stats();
		t_full();
		t_off();
		t_filt();
		end_of_test();
	end
endmodule
